// ---- bench/spsc_host_model.sv ----
// Host serial controller model driving data, clock and latch
`timescale 1ns/1ns
`default_nettype none
module spsc_host_model (
  // Clock
  input wire logic clk,
  // Serial link
  output var logic ser_clk,
  output var logic ser_data,
  output var logic ser_latch
);
  import spsc_pkg::*;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b0;
  end
  // ==========================================================
  // Half period of 4 clk, 80 ns serial clock
  task automatic half;
    repeat (4) @(posedge clk);
  endtask : half
  // ==========================================================
  // Word transfer, first bit sent is the highest
  task automatic send(input logic [10:0] bits, input int n, input bit latch);
    @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      ser_data <= bits[i];
      half();
      ser_clk <= 1'b1;
      half();
      ser_clk <= 1'b0;
    end
    if (n > 0) begin
      ser_data <= ~bits[0];
    end
    half();
    if (latch) begin
      ser_latch <= 1'b1;
      half();
      ser_latch <= 1'b0;
      half();
    end
  endtask : send
endmodule : spsc_host_model
`default_nettype wire

// ---- bench/spsc_top_tb_top.sv ----
// Self-checking bench of the serial power switch control
`timescale 1ns/1ns
`default_nettype none
module spsc_top_tb_top;
  import spsc_pkg::*;
  typedef struct packed {
    logic [10:0] bits;
    logic [3:0] n;
    logic [7:0] sel;
    logic [3:0] dis;
  } spsc_row_t;
  logic clk;
  logic rst_n;
  logic ser_clk;
  logic ser_data;
  logic ser_latch;
  logic fast_off_n;
  logic card_reset_n;
  logic [N_OUT-1:0] over_current;
  logic over_temp;
  logic die_cool;
  spsc_outs_t supply_sel;
  logic [N_OUT-1:0] discharge_en;
  logic [N_OUT-1:0] limit_en;
  logic fault_flag_n;
  int failures;
  int check_count;
  spsc_row_t rows [6];
  spsc_host_model host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch));
  spsc_top dut (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch), .fast_off_n(fast_off_n), .card_reset_n(card_reset_n),
    .over_current(over_current), .over_temp(over_temp), .die_cool(die_cool),
    .supply_sel(supply_sel), .discharge_en(discharge_en), .limit_en(limit_en),
    .fault_flag_n(fault_flag_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask : done
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic word(input logic [10:0] bits, input int n, input bit latch,
    input logic [7:0] sel);
    host.send(bits, n, latch);
    wt(2);
    chk(supply_sel, sel);
  endtask : word
  // ==========================================================
  // Watchdog
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    fast_off_n = 1'b1;
    card_reset_n = 1'b1;
    over_current = '0;
    over_temp = 1'b0;
    die_cool = 1'b0;
    failures = 0;
    check_count = 0;
    rows[0] = '{11'h100, 4'd9, 8'h55, 4'hf};
    rows[1] = '{11'h7a6, 4'd11, 8'haa, 4'h0};
    rows[2] = '{11'h0ff, 4'd9, 8'h00, 4'h0};
    rows[3] = '{11'h1ff, 4'd9, 8'h05, 4'h3};
    rows[4] = '{11'h145, 4'd9, 8'h7e, 4'h8};
    rows[5] = '{11'h159, 4'd9, 8'hff, 4'h0};
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk(supply_sel, OUTS_GND);
    chk({4'h0, discharge_en}, 8'h0f);
    chk({7'h0, fault_flag_n}, 8'h01);
    @(posedge clk) rst_n <= 1'b1;
    wt(4);
    chk(supply_sel, OUTS_GND);
    done("reset");
    for (int i = 0; i < 6; i++) begin
      word(rows[i].bits, int'(rows[i].n), 1'b1, rows[i].sel);
      chk({4'h0, discharge_en}, {4'h0, rows[i].dis});
    end
    done("decode");
    word(11'h100, 9, 1'b0, 8'hff);
    word(11'h000, 0, 1'b1, 8'h55);
    word(11'h108, 9, 1'b1, 8'h57);
    chk({4'h0, discharge_en}, 8'h0e);
    word(11'h100, 9, 1'b1, 8'h55);
    chk({4'h0, discharge_en}, 8'h0f);
    wt(20);
    word(11'h104, 9, 1'b1, 8'h56);
    chk({4'h0, discharge_en}, 8'h0e);
    word(11'h159, 9, 1'b1, 8'hff);
    done("hold");
    @(posedge clk) fast_off_n <= 1'b0;
    wt(5);
    chk(supply_sel, OUTS_HIZ);
    @(posedge clk) fast_off_n <= 1'b1;
    wt(5);
    chk(supply_sel, 8'hff);
    done("fast_off");
    for (int i = 0; i < N_OUT; i++) begin
      @(posedge clk) over_current <= 4'h1 << i;
      wt(5);
      chk({7'h0, fault_flag_n}, 8'h00);
      chk({4'h0, limit_en}, {4'h0, 4'h1 << i});
      chk(supply_sel, 8'hff);
    end
    @(posedge clk) over_current <= '0;
    over_temp <= 1'b1;
    wt(5);
    chk({7'h0, fault_flag_n}, 8'h00);
    chk(supply_sel, OUTS_HIZ);
    @(posedge clk) over_temp <= 1'b0;
    wt(5);
    chk({7'h0, fault_flag_n}, 8'h01);
    chk(supply_sel, OUTS_HIZ);
    @(posedge clk) die_cool <= 1'b1;
    wt(5);
    chk(supply_sel, 8'hff);
    @(posedge clk) die_cool <= 1'b0;
    done("faults");
    @(posedge clk) card_reset_n <= 1'b0;
    wt(5);
    chk(supply_sel, OUTS_GND);
    chk({4'h0, discharge_en}, 8'h0f);
    word(11'h1a6, 9, 1'b1, 8'h55);
    @(posedge clk) card_reset_n <= 1'b1;
    wt(5);
    chk(supply_sel, OUTS_GND);
    word(11'h159, 9, 1'b1, 8'hff);
    done("card_reset");
    report_and_stop();
  end
endmodule : spsc_top_tb_top
`default_nettype wire

// ---- verilog/spsc_pkg.sv ----
// Shared constants and types of the serial power switch control
`default_nettype none
package spsc_pkg;
  // ==========================================================
  // Word layout
  localparam int WORD_W = 9;
  localparam int POWER_ON_BIT = 8;
  localparam int PROG_A_HI = 0;
  localparam int PROG_A_LO = 1;
  localparam int MAIN_A_HI = 3;
  localparam int MAIN_A_LO = 2;
  localparam int PROG_B_HI = 4;
  localparam int PROG_B_LO = 5;
  localparam int MAIN_B_HI = 6;
  localparam int MAIN_B_LO = 7;
  localparam logic [WORD_W-1:0] WORD_RST = 9'h000;
  // ==========================================================
  // Output indices
  localparam int N_OUT = 4;
  localparam int IDX_MAIN_A = 0;
  localparam int IDX_MAIN_B = 1;
  localparam int IDX_PROG_A = 2;
  localparam int IDX_PROG_B = 3;
  localparam int SYNC_STAGES = 2;
  // ==========================================================
  // Switch selections
  typedef logic [1:0] spsc_sel_t;
  localparam spsc_sel_t SEL_HIZ = 2'h0;
  localparam spsc_sel_t SEL_GND = 2'h1;
  localparam spsc_sel_t SEL_LOW = 2'h2;
  localparam spsc_sel_t SEL_HIGH = 2'h3;
  typedef struct packed {
    spsc_sel_t prog_b;
    spsc_sel_t prog_a;
    spsc_sel_t main_b;
    spsc_sel_t main_a;
  } spsc_outs_t;
  localparam spsc_outs_t OUTS_GND = {SEL_GND, SEL_GND, SEL_GND, SEL_GND};
  localparam spsc_outs_t OUTS_HIZ = {SEL_HIZ, SEL_HIZ, SEL_HIZ, SEL_HIZ};
  // Pin sample bundle
  typedef struct packed {
    logic ser_clk;
    logic ser_data;
    logic ser_latch;
    logic fast_off_n;
    logic card_reset_n;
    logic over_temp;
    logic die_cool;
    logic [N_OUT-1:0] over_current;
  } spsc_pins_t;
  localparam int PINS_W = 7 + N_OUT;
endpackage : spsc_pkg
`default_nettype wire

// ---- verilog/spsc_sync.sv ----
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none
module spsc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // ==========================================================
  // Two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : spsc_sync
`default_nettype wire

// ---- verilog/spsc_top.sv ----
// Serial power switch control: shift, latch, decode and protection
`timescale 1ns/1ns
`default_nettype none
module spsc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_latch,
  // Control pins
  input wire logic fast_off_n,
  input wire logic card_reset_n,
  // Sensors
  input wire logic [spsc_pkg::N_OUT-1:0] over_current,
  input wire logic over_temp,
  input wire logic die_cool,
  // Switch drive
  output var spsc_pkg::spsc_outs_t supply_sel,
  output var logic [spsc_pkg::N_OUT-1:0] discharge_en,
  output var logic [spsc_pkg::N_OUT-1:0] limit_en,
  output var logic fault_flag_n
);
  import spsc_pkg::*;

  spsc_pins_t pins_raw;
  spsc_pins_t pins_s;
  logic ser_clk_d_reg;
  logic ser_latch_d_reg;
  logic ser_rise;
  logic latch_rise;
  logic card_rst;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] word_reg;
  logic word_valid_reg;
  logic thermal_trip_reg;
  spsc_outs_t outs_next;
  logic [N_OUT-1:0] discharge_next;
  logic [N_OUT-1:0] limit_next;

  // ==========================================================
  // Decode functions
  function automatic spsc_sel_t decode_main(input logic [1:0] code);
    case (code)
      2'h1: decode_main = SEL_LOW;
      2'h2: decode_main = SEL_HIGH;
      default: decode_main = SEL_GND;
    endcase
  endfunction : decode_main

  function automatic spsc_sel_t decode_prog(input logic [1:0] code);
    case (code)
      2'h0: decode_prog = SEL_GND;
      2'h1: decode_prog = SEL_LOW;
      2'h2: decode_prog = SEL_HIGH;
      default: decode_prog = SEL_HIZ;
    endcase
  endfunction : decode_prog

  function automatic logic sel_active(input spsc_sel_t s);
    sel_active = (s == SEL_LOW) || (s == SEL_HIGH);
  endfunction : sel_active

  // ==========================================================
  // Pin synchronisers
  assign pins_raw = {ser_clk, ser_data, ser_latch, fast_off_n, card_reset_n,
                     over_temp, die_cool, over_current};

  spsc_sync #(
    .W(PINS_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  // ==========================================================
  // Edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_clk_d_reg <= 1'b0;
      ser_latch_d_reg <= 1'b0;
    end else begin
      ser_clk_d_reg <= pins_s.ser_clk;
      ser_latch_d_reg <= pins_s.ser_latch;
    end
  end

  assign ser_rise = pins_s.ser_clk && !ser_clk_d_reg;
  assign latch_rise = pins_s.ser_latch && !ser_latch_d_reg;
  assign card_rst = !pins_s.card_reset_n;

  // ==========================================================
  // Shift register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= WORD_RST;
    end else if (ser_rise) begin
      shift_reg <= {shift_reg[WORD_W-2:0], pins_s.ser_data};
    end
  end

  // ==========================================================
  // Active word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= WORD_RST;
    end else if (latch_rise && !card_rst) begin
      word_reg <= shift_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_valid_reg <= 1'b0;
    end else if (card_rst) begin
      word_valid_reg <= 1'b0;
    end else if (latch_rise) begin
      word_valid_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Thermal shutdown with hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_trip_reg <= 1'b0;
    end else if (pins_s.over_temp) begin
      thermal_trip_reg <= 1'b1;
    end else if (pins_s.die_cool) begin
      thermal_trip_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Output selection
  always_comb begin
    outs_next = OUTS_GND;
    if (card_rst || !word_valid_reg) begin
      outs_next = OUTS_GND;
    end else if (!pins_s.fast_off_n) begin
      outs_next = OUTS_HIZ;
    end else if (!word_reg[POWER_ON_BIT]) begin
      outs_next = OUTS_HIZ;
    end else if (thermal_trip_reg || pins_s.over_temp) begin
      outs_next = OUTS_HIZ;
    end else begin
      outs_next.main_a = decode_main({word_reg[MAIN_A_HI], word_reg[MAIN_A_LO]});
      outs_next.main_b = decode_main({word_reg[MAIN_B_HI], word_reg[MAIN_B_LO]});
      outs_next.prog_a = decode_prog({word_reg[PROG_A_HI], word_reg[PROG_A_LO]});
      outs_next.prog_b = decode_prog({word_reg[PROG_B_HI], word_reg[PROG_B_LO]});
    end
  end

  always_comb begin
    discharge_next = '0;
    limit_next = '0;
    discharge_next[IDX_MAIN_A] = (outs_next.main_a == SEL_GND);
    discharge_next[IDX_MAIN_B] = (outs_next.main_b == SEL_GND);
    discharge_next[IDX_PROG_A] = (outs_next.prog_a == SEL_GND);
    discharge_next[IDX_PROG_B] = (outs_next.prog_b == SEL_GND);
    limit_next[IDX_MAIN_A] = pins_s.over_current[IDX_MAIN_A] && sel_active(outs_next.main_a);
    limit_next[IDX_MAIN_B] = pins_s.over_current[IDX_MAIN_B] && sel_active(outs_next.main_b);
    limit_next[IDX_PROG_A] = pins_s.over_current[IDX_PROG_A] && sel_active(outs_next.prog_a);
    limit_next[IDX_PROG_B] = pins_s.over_current[IDX_PROG_B] && sel_active(outs_next.prog_b);
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_sel <= OUTS_GND;
      discharge_en <= '1;
      limit_en <= '0;
    end else begin
      supply_sel <= outs_next;
      discharge_en <= discharge_next;
      limit_en <= limit_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_flag_n <= 1'b1;
    end else begin
      fault_flag_n <= !(|pins_s.over_current || pins_s.over_temp);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Reference decode for checks
  logic decode_on;
  logic [1:0] prog_b_code;
  spsc_sel_t exp_main_a;
  spsc_sel_t exp_prog_b;
  assign decode_on = word_valid_reg && !card_rst && pins_s.fast_off_n &&
                     word_reg[POWER_ON_BIT] && !thermal_trip_reg && !pins_s.over_temp;
  assign prog_b_code = {word_reg[PROG_B_HI], word_reg[PROG_B_LO]};
  assign exp_main_a = (word_reg[MAIN_A_HI:MAIN_A_LO] == 2'h1) ? SEL_LOW :
                      (word_reg[MAIN_A_HI:MAIN_A_LO] == 2'h2) ? SEL_HIGH : SEL_GND;
  assign exp_prog_b = (prog_b_code == 2'h0) ? SEL_GND :
                      (prog_b_code == 2'h1) ? SEL_LOW :
                      (prog_b_code == 2'h2) ? SEL_HIGH : SEL_HIZ;

  shift_in_a: assert property (ser_rise |=>
    shift_reg == {$past(shift_reg[WORD_W-2:0]), $past(pins_s.ser_data)})
    else $error("shift register did not take the data bit");
  latch_load_a: assert property (latch_rise && !card_rst |=>
    word_reg == $past(shift_reg) && word_valid_reg)
    else $error("latch edge did not load the word");
  word_hold_a: assert property (!latch_rise |=> $stable(word_reg))
    else $error("active word changed without a latch edge");
  reset_block_a: assert property (card_rst |=>
    !word_valid_reg ##1 supply_sel == OUTS_GND)
    else $error("latch accepted during card reset");
  reset_gnd_a: assert property (card_rst |=>
    supply_sel == OUTS_GND && discharge_en == '1)
    else $error("outputs not grounded in card reset");
  power_off_a: assert property (
    word_valid_reg && !card_rst && !word_reg[POWER_ON_BIT] |=> supply_sel == OUTS_HIZ)
    else $error("power-on bit low did not float outputs");
  fast_off_a: assert property (!pins_s.fast_off_n && word_valid_reg && !card_rst |=>
    supply_sel == OUTS_HIZ)
    else $error("fast-off pin did not float outputs");
  main_dec_a: assert property (decode_on |=>
    supply_sel.main_a == $past(exp_main_a) && supply_sel.prog_b == $past(exp_prog_b))
    else $error("main or programming selection wrong");
  prog_dec_a: assert property (
    decode_on && {word_reg[PROG_A_HI], word_reg[PROG_A_LO]} == 2'h3 |=>
    supply_sel.prog_a == SEL_HIZ)
    else $error("slot A programming code 11 not floating");
  fault_flag_a: assert property (|pins_s.over_current || pins_s.over_temp |=>
    !fault_flag_n)
    else $error("fault flag not asserted");
  discharge_a: assert property (supply_sel.main_b == SEL_GND |-> discharge_en[1])
    else $error("grounded output without discharge");
  thermal_a: assert property (
    pins_s.over_temp && !card_rst && word_valid_reg |=>
    supply_sel == OUTS_HIZ && thermal_trip_reg)
    else $error("overtemperature did not cut outputs");

  word_load_c: cover property (latch_rise && !card_rst ##1 word_reg[8]);
  reset_latch_c: cover property (latch_rise && card_rst);
  thermal_c: cover property (thermal_trip_reg ##1 !thermal_trip_reg);
endmodule : spsc_top
`default_nettype wire
